// >>> hw/heat_pkg.sv
package heat_pkg;
  // Channel and field counts; field list masks limit NUM_CH to 8
  localparam int NUM_CH  = 8;
  localparam int NUM_FLD = 4;
  localparam int CW      = $clog2(NUM_CH);
  localparam int FW      = $clog2(NUM_FLD);

  // Register map: fixed words, then one region per array
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] HOLD_OFS = 12'h004;
  localparam logic [11:0] NOMV_OFS = 12'h008;
  localparam logic [11:0] STAT_OFS = 12'h00C;
  localparam logic [5:0]  FSP_RGN  = 6'h01;
  localparam logic [5:0]  FDEF_RGN = 6'h02;
  localparam logic [5:0]  CSP_RGN  = 6'h03;
  localparam logic [5:0]  RATE_RGN = 6'h04;

  // Control word bit positions
  localparam int CTRL_HEAT  = 0;
  localparam int CTRL_PROD  = 1;
  localparam int CTRL_COMP  = 2;
  localparam int CTRL_FIELD = 3;
  localparam int CTRL_POWER = 4;
  localparam int CTRL_PHASE = 5;
  localparam int CTRL_SOFT  = 6;
  localparam int CTRL_ECON  = 7;
  localparam int CTRL_PP    = 8;

  // Field definition and field setpoint word layout
  localparam logic [1:0] FDEF_RANGE = 2'h1;
  localparam logic [1:0] FDEF_LIST  = 2'h2;
  localparam int FDEF_FIRST = 4;
  localparam int FDEF_LAST  = 8;
  localparam int FDEF_CNT   = 12;
  localparam int FDEF_MASK  = 16;
  localparam int FSP_PROD   = 8;

  // Reset values and limits
  localparam logic [15:0] FSP_RESET  = 16'h6464;
  localparam logic [8:0]  NOMV_RESET = 9'h0E6;
  localparam logic [13:0] CSP_MAX    = 14'h2580;
  localparam logic [6:0]  PCT_FULL   = 7'h64;
  localparam logic [21:0] PCT_DIV    = 22'h00_0064;

  // Timing, counted in mains half-waves
  localparam int HALFWAVE_MS = 10;
  localparam int STARTUP_MS  = 3000;
  localparam int STARTUP_HW  = STARTUP_MS / HALFWAVE_MS;
  localparam logic [8:0] STAGGER_HW   = 9'(STARTUP_HW / NUM_CH);
  localparam logic [6:0] PER_HALFWAVE = 7'h64;
  localparam logic [6:0] PER_PHASE    = 7'h15;
  localparam logic [6:0] BOOST_HW     = 7'h0A;

  typedef struct packed {
    logic       enable;
    logic       conduct;
    logic [6:0] setpoint;
  } ch_out_t;

  typedef struct packed {
    logic                          zc_s1;
    logic                          zc_s2;
    logic                          zc_s3;
    logic [3:0]                    flt_s1;
    logic [3:0]                    flt_s2;
    logic                          rdy;
    logic [31:0]                   prdata;
    logic [8:0]                    ctrl;
    logic [NUM_CH-1:0]             hold;
    logic [8:0]                    nom_v;
    logic [NUM_FLD-1:0][15:0]      fsp;
    logic [NUM_FLD-1:0][23:0]      fdef;
    logic [NUM_CH-1:0][13:0]       csp;
    logic [NUM_CH-1:0][13:0]       rating;
    logic                          data_seen;
    logic                          heat_prev;
    logic                          seq;
    logic [CW-1:0]                 seq_idx;
    logic [8:0]                    seq_cnt;
    logic [6:0]                    per;
    logic [NUM_CH-1:0]             started;
    logic [NUM_CH-1:0]             on;
    logic [NUM_CH-1:0]             soft_on;
    logic [NUM_CH-1:0]             pwr_err;
    logic [NUM_CH-1:0][6:0]        ramp;
    logic [NUM_CH-1:0][6:0]        boost;
    logic [NUM_CH-1:0][6:0]        duty;
    logic [NUM_CH-1:0][6:0]        acc;
    ch_out_t [NUM_CH-1:0]          chout;
  } state_t;
endpackage

// >>> hw/heating_setpoint_output_control.sv
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/10ps
//
// Contract
// RULE_01 - Heating must be switched on before any channel drives; off keeps all off
// RULE_02 - At heating on, output modules start staggered in ascending slot order
// RULE_03 - Channels inside a module start one after another, not together
// RULE_04 - Whole staggered start-up completes within 3 seconds
// RULE_05 - Channel back from 0% restarts at once, or via soft start if set
// RULE_06 - Setpoint-only control uses channel setpoints, ignores standby/production
// RULE_07 - Field control scales by standby or production field setpoint per mode
// RULE_08 - Resulting setpoint is field setpoint times channel setpoint over 100
// RULE_09 - Fields are a first-last channel range or a counted channel list
// RULE_10 - Unassigned channels fall in field 0, kept at 100% by software
// RULE_11 - Compensation multiplies setpoint by squared nominal over measured voltage
// RULE_12 - Phase-to-phase modules use nominal voltage times square root of 3
// RULE_13 - Economy circuit connection gets no voltage compensation
// RULE_14 - Software keeps nominal voltage 207-300 V, or from 40 V flexible
// RULE_15 - Power control takes channel setpoints 0-9600 W; field setpoints stay percent
// RULE_16 - Unreachable power raises an error but the channel stays on
// RULE_17 - Half-wave power control recomputes the setpoint every 100 half-waves
// RULE_18 - Phase angle power control recomputes the setpoint every 21 half-waves
// RULE_19 - Power control starts at 100% for set half-waves, or after soft start
// RULE_20 - On link loss each output switches off or holds last value
// RULE_21 - Overtemperature, 24 V loss, voltage or frequency fault force all off
// RULE_22 - Outputs stay off after power-up until first user data arrives
// RULE_23 - Half-wave duty is N of 100, balanced positive and negative
// RULE_24 - Resulting setpoint saturates at 100 percent
module heating_setpoint_output_control (
  input  wire logic                               clock,
  input  wire logic                               resetn,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [11:0]                        paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               zero_cross,
  input  wire logic                               overtemp,
  input  wire logic                               supply24_fail,
  input  wire logic                               volt_range_err,
  input  wire logic                               freq_range_err,
  input  wire logic                               comm_ok,
  input  wire logic [9:0]                         line_voltage,
  output heat_pkg::ch_out_t [heat_pkg::NUM_CH-1:0] ch_out,
  output logic [heat_pkg::NUM_CH-1:0]             power_err
);

  heat_pkg::state_t s;
  heat_pkg::state_t n;
  logic             tick;
  logic             pos;
  logic             fault;
  logic             hit;
  logic [31:0]      rd_val;
  logic [3:0]       idx;

  // Saturate any scaled value at full conduction
  function automatic logic [6:0] sat100(input logic [26:0] v);
    // RULE_24 - clamp to 100
    sat100 = (v > 27'(heat_pkg::PCT_FULL)) ? heat_pkg::PCT_FULL : v[6:0];
  endfunction

  // Register read decode; unmapped words answer with an error
  always_comb begin
    idx    = paddr[5:2];
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr[11:6])
      6'h00: begin
        case (paddr)
          heat_pkg::CTRL_OFS: rd_val = 32'(s.ctrl);
          heat_pkg::HOLD_OFS: rd_val = 32'(s.hold);
          heat_pkg::NOMV_OFS: rd_val = 32'(s.nom_v);
          heat_pkg::STAT_OFS: rd_val = 32'({s.on, s.pwr_err, 3'h0,
                                           comm_ok, fault, s.data_seen,
                                           s.seq, |s.on});
          default:            hit = 1'b0;
        endcase
      end
      heat_pkg::FSP_RGN: begin
        hit = idx < 4'(heat_pkg::NUM_FLD);
        if (hit) begin
          rd_val = 32'(s.fsp[idx[heat_pkg::FW-1:0]]);
        end
      end
      heat_pkg::FDEF_RGN: begin
        hit = idx < 4'(heat_pkg::NUM_FLD);
        if (hit) begin
          rd_val = 32'(s.fdef[idx[heat_pkg::FW-1:0]]);
        end
      end
      heat_pkg::CSP_RGN: begin
        hit = idx < 4'(heat_pkg::NUM_CH);
        if (hit) begin
          rd_val = 32'(s.csp[idx[heat_pkg::CW-1:0]]);
        end
      end
      heat_pkg::RATE_RGN: begin
        hit = idx < 4'(heat_pkg::NUM_CH);
        if (hit) begin
          rd_val = 32'(s.rating[idx[heat_pkg::CW-1:0]]);
        end
      end
      default: hit = 1'b0;
    endcase
  end

  // Whole next-state computation
  always_comb begin
    logic [heat_pkg::FW-1:0] f;
    logic [23:0]             d;
    logic [7:0]              fp;
    logic [13:0]             cs;
    logic [21:0]             scaled;
    logic [6:0]              pre;
    logic [6:0]              fin;
    logic [6:0]              out;
    logic [19:0]             vn2;
    logic [19:0]             den;
    logic [26:0]             num;
    logic [28:0]             est;
    logic [28:0]             tgt;
    logic                    want;
    logic                    en;
    logic                    wrap;
    logic                    wr;
    logic [6:0]              lim;
    logic [7:0]              sum;
    f      = '0;
    d      = '0;
    fp     = '0;
    cs     = '0;
    scaled = '0;
    pre    = '0;
    fin    = '0;
    out    = '0;
    vn2    = '0;
    den    = '0;
    num    = '0;
    est    = '0;
    tgt    = '0;
    want   = 1'b0;
    en     = 1'b0;
    wr     = 1'b0;
    wrap   = 1'b0;
    lim    = '0;
    sum    = '0;
    n      = s;

    // Mains zero crossings and fault pins come from outside: two stages
    n.zc_s1  = zero_cross;
    n.zc_s2  = s.zc_s1;
    n.zc_s3  = s.zc_s2;
    n.flt_s1 = {overtemp, supply24_fail, volt_range_err, freq_range_err};
    n.flt_s2 = s.flt_s1;
    tick     = s.zc_s2 ^ s.zc_s3;
    pos      = tick & s.zc_s2;
    fault    = |s.flt_s2;

    // APB: one wait state so read data leaves a flip-flop
    n.rdy = psel & penable & ~s.rdy;
    if (psel & penable & ~s.rdy) begin
      n.prdata = rd_val;
    end
    wr = psel & penable & pwrite & s.rdy & hit;
    if (wr) begin
      case (paddr[11:6])
        6'h00: begin
          if (paddr == heat_pkg::CTRL_OFS) begin
            n.ctrl = pwdata[8:0];
            // RULE_22 - first user data seen
            n.data_seen = 1'b1;
          end
          if (paddr == heat_pkg::HOLD_OFS) begin
            n.hold = pwdata[heat_pkg::NUM_CH-1:0];
          end
          if (paddr == heat_pkg::NOMV_OFS) begin
            n.nom_v = pwdata[8:0];
          end
        end
        heat_pkg::FSP_RGN:  n.fsp[idx[heat_pkg::FW-1:0]] = pwdata[15:0];
        heat_pkg::FDEF_RGN: n.fdef[idx[heat_pkg::FW-1:0]] = pwdata[23:0];
        heat_pkg::CSP_RGN:  n.csp[idx[heat_pkg::CW-1:0]] = pwdata[13:0];
        heat_pkg::RATE_RGN: n.rating[idx[heat_pkg::CW-1:0]] = pwdata[13:0];
        default: ;
      endcase
    end

    // Regulation period counter, fixed per modulation type
    // RULE_17 - 100 half-wave period
    // RULE_18 - 21 half-wave period
    lim  = s.ctrl[heat_pkg::CTRL_PHASE] ? heat_pkg::PER_PHASE
                                        : heat_pkg::PER_HALFWAVE;
    wrap = tick && (s.per >= lim - 7'h01);
    if (tick) begin
      n.per = wrap ? 7'h00 : s.per + 7'h01;
    end

    // Start-up stagger: channel index runs module by module by slot
    n.heat_prev = s.ctrl[heat_pkg::CTRL_HEAT];
    if (!s.ctrl[heat_pkg::CTRL_HEAT]) begin
      // RULE_01 - heating off clears all
      n.started = '0;
      n.seq     = 1'b0;
    end else if (!s.heat_prev) begin
      n.seq     = 1'b1;
      n.seq_idx = '0;
      n.seq_cnt = heat_pkg::STAGGER_HW - 9'h001;
    end else if (s.seq && tick) begin
      // RULE_02 - modules in slot order
      // RULE_03 - channels one at a time
      // RULE_04 - stagger fits 3 s
      if (s.seq_cnt >= heat_pkg::STAGGER_HW - 9'h001) begin
        n.started[s.seq_idx] = 1'b1;
        n.seq_cnt            = '0;
        n.seq_idx            = s.seq_idx + 1'b1;
        if (s.seq_idx == heat_pkg::CW'(heat_pkg::NUM_CH - 1)) begin
          n.seq = 1'b0;
        end
      end else begin
        n.seq_cnt = s.seq_cnt + 9'h001;
      end
    end

    for (int c = 0; c < heat_pkg::NUM_CH; c++) begin
      // RULE_09 - range or listed fields
      // RULE_10 - default field 0
      f = '0;
      for (int k = heat_pkg::NUM_FLD - 1; k >= 1; k--) begin
        d = s.fdef[k];
        if (d[1:0] == heat_pkg::FDEF_RANGE &&
            4'(c) >= d[heat_pkg::FDEF_FIRST +: 4] &&
            4'(c) <= d[heat_pkg::FDEF_LAST +: 4]) begin
          f = heat_pkg::FW'(k);
        end
        if (d[1:0] == heat_pkg::FDEF_LIST &&
            d[heat_pkg::FDEF_CNT +: 4] != 4'h0 &&
            d[heat_pkg::FDEF_MASK + c]) begin
          f = heat_pkg::FW'(k);
        end
      end
      // RULE_06 - mode ignored without fields
      // RULE_07 - standby or production
      fp = 8'(heat_pkg::PCT_FULL);
      if (s.ctrl[heat_pkg::CTRL_FIELD]) begin
        fp = s.ctrl[heat_pkg::CTRL_PROD]
             ? s.fsp[f][heat_pkg::FSP_PROD +: 8] : s.fsp[f][7:0];
      end
      // RULE_15 - watts or percent
      cs = s.csp[c];
      if (cs > heat_pkg::CSP_MAX) begin
        cs = heat_pkg::CSP_MAX;
      end
      if (!s.ctrl[heat_pkg::CTRL_POWER] && cs > 14'(heat_pkg::PCT_FULL)) begin
        cs = 14'(heat_pkg::PCT_FULL);
      end
      // RULE_08 - field times channel over 100
      scaled = (22'(cs) * 22'(fp)) / heat_pkg::PCT_DIV;
      pre    = s.ctrl[heat_pkg::CTRL_POWER] ? s.duty[c]
                                            : sat100(27'(scaled));
      // RULE_11 - squared voltage ratio
      // RULE_12 - phase-phase gets factor 3
      vn2 = 20'(s.nom_v) * 20'(s.nom_v);
      if (s.ctrl[heat_pkg::CTRL_PP]) begin
        vn2 = 20'(vn2 * 20'h0_0003);
      end
      den = 20'(line_voltage) * 20'(line_voltage);
      fin = pre;
      // RULE_13 - economy circuit skipped
      if (s.ctrl[heat_pkg::CTRL_COMP] && !s.ctrl[heat_pkg::CTRL_ECON] &&
          den != 20'h0_0000) begin
        num = 27'(pre) * 27'(vn2);
        fin = sat100(num / 27'(den));
      end
      want = s.ctrl[heat_pkg::CTRL_POWER] ? (scaled != 22'h00_0000)
                                          : (fin != 7'h00);
      // RULE_20 - link loss off or hold
      // RULE_21 - faults force off
      // RULE_22 - nothing before user data
      en = s.ctrl[heat_pkg::CTRL_HEAT] & s.data_seen & ~fault &
           (comm_ok | s.hold[c]) & s.started[c] & want;
      n.on[c] = en;

      // RULE_05 - immediate or soft restart
      // RULE_19 - boost at 100% first
      if (en && !s.on[c]) begin
        n.ramp[c]  = '0;
        n.boost[c] = '0;
        n.soft_on[c] = s.ctrl[heat_pkg::CTRL_SOFT];
        if (!s.ctrl[heat_pkg::CTRL_SOFT] && s.ctrl[heat_pkg::CTRL_POWER]) begin
          n.boost[c] = heat_pkg::BOOST_HW;
        end
      end else if (!en) begin
        n.soft_on[c] = 1'b0;
        n.boost[c]   = '0;
      end else if (tick) begin
        if (s.soft_on[c]) begin
          n.ramp[c] = s.ramp[c] + 7'h01;
          if (s.ramp[c] >= fin) begin
            n.soft_on[c] = 1'b0;
            if (s.ctrl[heat_pkg::CTRL_POWER]) begin
              n.duty[c] = fin;
            end
          end
        end
        if (s.boost[c] != 7'h00) begin
          n.boost[c] = s.boost[c] - 7'h01;
        end
      end

      // Closed loop: estimated power from rating and duty
      est = 29'(s.rating[c]) * 29'(s.duty[c]);
      tgt = 29'(scaled) * 29'(heat_pkg::PCT_FULL);
      if (!s.ctrl[heat_pkg::CTRL_POWER] || !en) begin
        n.pwr_err[c] = 1'b0;
      end else if (wrap && !s.soft_on[c] && s.boost[c] == 7'h00) begin
        // RULE_16 - flag, stay on
        n.pwr_err[c] = (s.duty[c] >= heat_pkg::PCT_FULL) && (est < tgt);
        if (est < tgt && s.duty[c] < heat_pkg::PCT_FULL) begin
          n.duty[c] = s.duty[c] + 7'h01;
        end else if (est > tgt && s.duty[c] != 7'h00) begin
          n.duty[c] = s.duty[c] - 7'h01;
        end
      end

      out = fin;
      if (s.soft_on[c]) begin
        out = (s.ramp[c] < fin) ? s.ramp[c] : fin;
      end else if (s.boost[c] != 7'h00) begin
        out = heat_pkg::PCT_FULL;
      end
      if (!s.on[c]) begin
        out = '0;
      end

      // RULE_23 - whole waves, so polarities stay balanced
      if (!s.on[c] || s.ctrl[heat_pkg::CTRL_PHASE]) begin
        n.acc[c]           = '0;
        n.chout[c].conduct = 1'b0;
      end else if (pos) begin
        sum = 8'(s.acc[c]) + 8'(out);
        n.chout[c].conduct = sum >= 8'(heat_pkg::PCT_FULL);
        n.acc[c] = (sum >= 8'(heat_pkg::PCT_FULL))
                   ? 7'(sum - 8'(heat_pkg::PCT_FULL)) : sum[6:0];
      end
      n.chout[c].enable   = s.on[c];
      n.chout[c].setpoint = out;
    end

    // Synchronous reset: field setpoints start at full scale
    if (!resetn) begin
      n       = '0;
      n.nom_v = heat_pkg::NOMV_RESET;
      n.fsp   = {heat_pkg::NUM_FLD{heat_pkg::FSP_RESET}};
    end
  end

  // Single state register
  always_ff @(posedge clock) begin
    s <= n;
  end

  // Outputs
  assign prdata    = s.prdata;
  assign pready    = s.rdy;
  assign pslverr   = s.rdy & ~hit;
  assign ch_out    = s.chout;
  assign power_err = s.pwr_err;

endmodule

// >>> tb/heat_chk.sv
`timescale 1ns/10ps
// Port checker; shadows control and hold words
module heat_chk (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        overtemp,
  input wire logic        supply24_fail,
  input wire logic        volt_range_err,
  input wire logic        freq_range_err,
  input wire logic        comm_ok,
  input wire heat_pkg::ch_out_t [heat_pkg::NUM_CH-1:0] ch_out
);
  logic [8:0]                  ctrl_q;
  logic [heat_pkg::NUM_CH-1:0] hold_q, en, cd, over;
  logic                        wr_done;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  assign wr_done = psel && penable && pready && pwrite;
  // Shadow words change only where the slave takes a write
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl_q <= '0;
      hold_q <= '0;
    end else if (wr_done && paddr == heat_pkg::CTRL_OFS) begin
      ctrl_q <= pwdata[8:0];
    end else if (wr_done && paddr == heat_pkg::HOLD_OFS) begin
      hold_q <= pwdata[heat_pkg::NUM_CH-1:0];
    end
  end
  // Per-channel flags
  always_comb begin
    for (int i = 0; i < heat_pkg::NUM_CH; i++) begin
      en[i]   = ch_out[i].enable;
      cd[i]   = ch_out[i].conduct;
      over[i] = ch_out[i].setpoint > heat_pkg::PCT_FULL;
    end
  end
  property p_rdy_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
  property p_rdy_one;
    pready |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready too long");
  property p_err;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("stray pslverr");
  property p_fault;
    (overtemp || supply24_fail || volt_range_err || freq_range_err) [*6]
      |-> en == '0;
  endproperty
  a_fault: assert property (p_fault) else $error("on during fault");
  property p_heat;
    !ctrl_q[heat_pkg::CTRL_HEAT] [*4] |-> en == '0;
  endproperty
  a_heat: assert property (p_heat) else $error("on with heat off");
  property p_link;
    !comm_ok [*4] |-> (en & ~hold_q) == '0;
  endproperty
  a_link: assert property (p_link) else $error("on after link loss");
  property p_sat;
    over == '0;
  endproperty
  a_sat: assert property (p_sat) else $error("setpoint above full");
  property p_cond;
    (cd & ~en) == '0;
  endproperty
  a_cond: assert property (p_cond) else $error("conduct while off");
  property p_pa;
    ctrl_q[heat_pkg::CTRL_PHASE] [*4] |-> cd == '0;
  endproperty
  a_pa: assert property (p_pa) else $error("gate in phase mode");
endmodule

// >>> tb/ctl_model.sv
`timescale 1ns/10ps
// Controller side of the register bus
module ctl_model (
  input  wire logic        clock,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end
  // Request held until pready is sampled high, then released
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic nomv(input int v);
    wr(heat_pkg::NOMV_OFS, 32'(v < 207 ? 207 : (v > 300 ? 300 : v)));
  endtask
endmodule

// >>> tb/heating_setpoint_output_control_tb.sv
`timescale 1ns/10ps
module heating_setpoint_output_control_tb;
  localparam int HW = 10; // Clocks per half-wave, mains shortened
  localparam int NC = heat_pkg::NUM_CH;
  logic                              clock, resetn, zc, comm_ok;
  logic                              psel, penable, pwrite, pready, pslverr;
  logic [3:0]                        flt;
  logic [9:0]                        vline;
  logic [11:0]                       paddr;
  logic [31:0]                       pwdata, prdata;
  logic [NC-1:0]                     pwr_err, en, cd;
  heat_pkg::ch_out_t [NC-1:0]        ch_out;
  int                                fail_count, cmp_count, hwc;
  int                                csp[NC];
  ctl_model ctl (.clock(clock), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  heating_setpoint_output_control DUT (.clock(clock), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zero_cross(zc), .overtemp(flt[0]), .supply24_fail(flt[1]),
    .volt_range_err(flt[2]), .freq_range_err(flt[3]), .comm_ok(comm_ok),
    .line_voltage(vline), .ch_out(ch_out), .power_err(pwr_err));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Mains polarity and half-wave count
  initial begin
    zc  = 1'b0;
    hwc = 0;
    forever begin
      repeat (HW) @(posedge clock);
      zc  <= ~zc;
      hwc <= hwc + 1;
    end
  end
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      en[i] = ch_out[i].enable;
      cd[i] = ch_out[i].conduct;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x,
                     input int tol = 0);
    cmp_count++;
    if (^s === 1'bx || (s > x ? s - x : x - s) > tol) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, s, x);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wait_hw(input int n);
    repeat (n * HW) @(posedge clock);
  endtask
  task automatic ctrl(input logic [8:0] v);
    ctl.wr(heat_pkg::CTRL_OFS, 32'(v));
  endtask
  // Waits, bounded, for channel 0's setpoint to move
  task automatic wchg(output int t);
    logic [6:0] v;
    v = ch_out[0].setpoint;
    repeat (300 * HW) if (ch_out[0].setpoint === v) @(posedge clock);
    t = hwc;
  endtask
  function automatic logic [11:0] ra(input logic [5:0] r, input int i);
    return {r, 4'(i), 2'b00};
  endfunction
  function automatic int sat(input int v);
    return v > 100 ? 100 : v;
  endfunction
  initial begin
    logic [31:0] d;
    logic        e;
    logic [7:0]  m;
    int          t[NC];
    int          n, p, s, f, t1;
    resetn     = 1'b0;
    comm_ok    = 1'b1;
    flt        = 4'h0;
    vline      = 10'h0E6;
    fail_count = 0;
    cmp_count  = 0;
    void'($urandom(21178));
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    ctl.xfer(1'b0, heat_pkg::CTRL_OFS, '0, d, e);
    chk(d, 0);
    ctl.xfer(1'b0, heat_pkg::NOMV_OFS, '0, d, e);
    chk(d, 32'(heat_pkg::NOMV_RESET));
    ctl.xfer(1'b0, ra(heat_pkg::FSP_RGN, 0), '0, d, e);
    chk(d, 32'(heat_pkg::FSP_RESET));
    ctl.xfer(1'b0, 12'hFFC, '0, d, e);
    chk({e, d[30:0]}, 32'h8000_0000);
    for (int c = 0; c < NC; c++) begin
      csp[c] = 1 + $urandom % 100;
      ctl.wr(ra(heat_pkg::CSP_RGN, c), csp[c]);
    end
    wait_hw(3);
    chk(en, 0);
    ctrl(9'h000);
    wait_hw(3);
    chk(en, 0);
    $display("test reset done");
    t = '{default: -1};
    ctrl(9'h001 | 9'($urandom % 2) << 1);
    s = hwc;
    repeat (320 * HW) begin
      @(posedge clock);
      for (int c = 0; c < NC; c++)
        if (en[c] && t[c] < 0) t[c] = hwc - s;
    end
    for (int c = 0; c < NC; c++) begin
      chk(t[c], c * heat_pkg::STAGGER_HW, 2);
      if (c > 0) chk(t[c] > t[c-1], 1);
      chk(ch_out[c].setpoint, csp[c]);
    end
    chk(t[NC-1] < heat_pkg::STARTUP_HW, 1);
    ctrl(9'h003);
    wait_hw(3);
    for (int c = 0; c < NC; c++) chk(ch_out[c].setpoint, csp[c]);
    $display("test startup done");
    p = $urandom % 101;
    s = $urandom % 101;
    // field 0 left at full scale
    ctl.wr(ra(heat_pkg::FSP_RGN, 1), 32'({p[7:0], s[7:0]}));
    ctl.wr(ra(heat_pkg::FSP_RGN, 2), 32'h0000_9696);
    ctl.wr(ra(heat_pkg::FDEF_RGN, 1), 32'h0000_0421);
    ctl.wr(ra(heat_pkg::FDEF_RGN, 2), 32'h00C0_2002);
    for (int md = 0; md < 2; md++) begin
      ctrl(9'h009 | 9'(md << 1));
      wait_hw(3);
      for (int c = 0; c < NC; c++) begin
        f = (c >= 2 && c <= 4) ? (md ? p : s) : (c > 5 ? 150 : 100);
        chk(ch_out[c].setpoint, sat(f * csp[c] / 100));
      end
    end
    $display("test fields done");
    ctl.nomv(230);
    vline <= 10'(200 + $urandom % 61);
    ctrl(9'h005);
    wait_hw(3);
    for (int c = 0; c < NC; c++)
      chk(ch_out[c].setpoint, sat(csp[c] * 52900 / (vline * vline)), 1);
    vline <= 10'h190;
    ctrl(9'h105);
    wait_hw(3);
    for (int c = 0; c < NC; c++)
      chk(ch_out[c].setpoint, sat(csp[c] * 158700 / 160000), 1);
    ctrl(9'h085);
    wait_hw(3);
    for (int c = 0; c < NC; c++) chk(ch_out[c].setpoint, csp[c]);
    vline <= 10'h0E6;
    $display("test compensation done");
    ctrl(9'h001);
    m = 8'($urandom);
    ctl.wr(heat_pkg::HOLD_OFS, 32'(m));
    comm_ok <= 1'b0;
    wait_hw(1);
    chk(en, m);
    comm_ok <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wait_hw(3);
      chk(en, 8'hFF);
      flt <= 4'(1 << k);
      wait_hw(1);
      chk(en, 0);
      flt <= 4'h0;
    end
    ctl.wr(ra(heat_pkg::CSP_RGN, 3), 0);
    wait_hw(3);
    chk(ch_out[3].setpoint, 0);
    ctl.wr(ra(heat_pkg::CSP_RGN, 3), 40);
    wait_hw(3);
    chk(en[3], 1);
    $display("test faults done");
    n = 1 + $urandom % 99;
    ctl.wr(ra(heat_pkg::CSP_RGN, 0), n);
    wait_hw(200);
    s = 0;
    repeat (100) begin
      @(posedge zc);
      repeat (HW / 2) @(posedge clock);
      s += cd[0];
    end
    chk(s, n, 2);
    $display("test duty done");
    ctl.wr(ra(heat_pkg::RATE_RGN, 0), 1000);
    ctl.wr(ra(heat_pkg::CSP_RGN, 0), 500);
    for (int ph = 1; ph >= 0; ph--) begin
      ctrl(ph ? 9'h031 : 9'h011);
      wchg(t1);
      wchg(t1);
      wchg(n);
      chk(n - t1, ph ? heat_pkg::PER_PHASE : heat_pkg::PER_HALFWAVE, 1);
      if (ph) begin
        ctl.wr(ra(heat_pkg::CSP_RGN, 0), 32'(heat_pkg::CSP_MAX));
        wait_hw(105 * 21);
        chk(pwr_err[0], 1);
        chk(en[0], 1);
        ctl.wr(ra(heat_pkg::CSP_RGN, 0), 500);
      end
    end
    ctrl(9'h000);
    wait_hw(2);
    chk(en, 0);
    $display("test power done");
    conclude();
  end
  // Hang guard, far beyond the planned run
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    conclude();
  end
endmodule
bind heating_setpoint_output_control heat_chk u_chk (.clock(clock),
  .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .overtemp(overtemp), .supply24_fail(supply24_fail),
  .volt_range_err(volt_range_err), .freq_range_err(freq_range_err),
  .comm_ok(comm_ok), .ch_out(ch_out));
